// ---- core/serial_port_map.svh ----
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH
// Register word addresses
`define CTRL_ADDR 2'h0
`define CFG_ADDR  2'h1
`define DATA_ADDR 2'h2
// Control register fields
`define DONE_BIT  7
`define WRITE_COLLISION_FLAG_BIT  6
`define MODE_FAULT_FLAG_BIT  5
`define OVR_BIT   4
`define SELHI_BIT 3
`define SELLO_BIT 2
`define TXE_BIT   1
`define EN_BIT    0
`define CTRL_RST  8'h04
// Configuration register fields
`define BUSY_BIT   7
`define MASTER_ENABLE_BIT_BIT  6
`define SLVSEL_BIT 3
`define SELIN_BIT  2
`define SRMT_BIT   1
`define RXBMT_BIT  0
// Select modes
`define SEL_3WIRE 2'h0
`define SEL_MULTI 2'h1
`define SEL_RST   2'h1
// Byte framing and master clock
`define LAST_BIT  3'h7
`define HALF_DIV  4
`endif

// ---- core/serial_port_pkg.sv ----
`default_nettype none
package serial_port_pkg;
  // Gray along idle, low, high, last
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_LOW  = 2'b01,
    M_HIGH = 2'b11,
    M_LAST = 2'b10
  } master_state_t;
endpackage
`default_nettype wire

// ---- core/serial_port.sv ----
// The implementer's own choices: strobed register access and the placing of the registers.
`include "serial_port_map.svh"
`default_nettype none
module serial_port
  import serial_port_pkg::*;
#(
  parameter int HALF_DIV = `HALF_DIV
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       sckIn,
  output logic            sckOut,
  output logic            sckOe,
  input  wire logic       mosiIn,
  output logic            mosiOut,
  output logic            mosiOe,
  input  wire logic       misoIn,
  output logic            misoOut,
  output logic            misoOe,
  input  wire logic       selNIn,
  output logic            selNOut,
  output logic            selNOe,
  output logic            selRouted
);

  logic [2:0]    sckS_reg;
  logic [1:0]    mosiS_reg;
  logic [1:0]    misoS_reg;
  logic [2:0]    selS_reg;
  logic          enable_reg;
  logic          master_reg;
  logic [1:0]    mode_reg;
  logic          done_reg;
  logic          write_collision_flag_reg;
  logic          mode_fault_flag_reg;
  logic          ovr_reg;
  logic [7:0]    txBuf_reg;
  logic          txFull_reg;
  logic [7:0]    shift_reg;
  logic          shEmpty_reg;
  logic [7:0]    rxBuf_reg;
  logic          rxEmpty_reg;
  logic [2:0]    bitCnt_reg;
  logic          sample_reg;
  master_state_t mState_reg;
  logic [7:0]    halfCnt_reg;
  logic          sck_reg;
  logic [7:0]    rdata_reg;
  logic          sckOe_reg;
  logic          misoOe_reg;
  logic          selNOe_reg;
  logic          routed_reg;

  // A bit-select needs a named constant, not a literal
  localparam logic [7:0] CTRL_RESET = `CTRL_RST;

  function automatic logic edgeOf(input logic prev, input logic cur, input logic rising);
    edgeOf = rising ? (~prev & cur) : (prev & ~cur);
  endfunction

  logic selLow;
  logic selFall;
  logic sckRise;
  logic masterOn;
  logic slaveOn;
  logic modeFault;
  logic wrData;
  logic wrCtrl;
  logic wrCfg;
  logic rdData;
  logic wcolEv;
  logic halfEnd;
  logic masterStart;
  logic slaveLoad;
  logic slaveDone;
  logic masterDone;

  // Only the second and third sync stages feed logic
  assign selLow   = ~selS_reg[1];
  assign selFall  = edgeOf(selS_reg[2], selS_reg[1], 1'b0);
  assign sckRise  = edgeOf(sckS_reg[2], sckS_reg[1], 1'b1);
  assign masterOn = enable_reg & master_reg;
  assign slaveOn  = enable_reg & ~master_reg
                  & ((mode_reg == `SEL_3WIRE)
                  | ((mode_reg == `SEL_MULTI) & selLow));
  assign modeFault = masterOn & (mode_reg == `SEL_MULTI) & selFall;
  assign wrData  = wr & (addr == `DATA_ADDR);
  assign wrCtrl  = wr & (addr == `CTRL_ADDR);
  assign wrCfg   = wr & (addr == `CFG_ADDR);
  assign rdData  = rd & (addr == `DATA_ADDR);
  assign wcolEv  = wrData & txFull_reg;
  assign halfEnd = (halfCnt_reg == 8'(HALF_DIV - 1));
  assign masterStart = masterOn & ~modeFault & (mState_reg == M_IDLE)
                     & txFull_reg & shEmpty_reg;
  // Slave only reloads between bytes, never starts a transfer
  assign slaveLoad = enable_reg & ~master_reg & shEmpty_reg
                   & txFull_reg & (bitCnt_reg == 3'h0);
  assign slaveDone  = slaveOn & sckRise & (bitCnt_reg == `LAST_BIT);
  assign masterDone = (mState_reg == M_LAST);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sckS_reg  <= 3'h0;
      mosiS_reg <= 2'h0;
      misoS_reg <= 2'h0;
      selS_reg  <= 3'h7;
    end else begin
      sckS_reg  <= {sckS_reg[1:0], sckIn};
      mosiS_reg <= {mosiS_reg[0], mosiIn};
      misoS_reg <= {misoS_reg[0], misoIn};
      selS_reg  <= {selS_reg[1:0], selNIn};
    end
  end

  // Control bits; fault wins over a software enable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      enable_reg <= CTRL_RESET[`EN_BIT];
      mode_reg   <= `SEL_RST;
      master_reg <= 1'b0;
    end else begin
      if (wrCtrl) begin
        enable_reg <= wdata[`EN_BIT];
        mode_reg   <= wdata[`SELHI_BIT:`SELLO_BIT];
      end
      if (wrCfg) begin
        master_reg <= wdata[`MASTER_ENABLE_BIT_BIT];
      end
      if (modeFault) begin
        enable_reg <= 1'b0;
        master_reg <= 1'b0;
      end
    end
  end

  // Sticky flags: software writes 0 to clear, a set in the same cycle wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      done_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
      ovr_reg  <= 1'b0;
    end else begin
      done_reg <= (masterDone | slaveDone)
                | (done_reg & ~(wrCtrl & ~wdata[`DONE_BIT]));
      write_collision_flag_reg <= wcolEv | (write_collision_flag_reg & ~(wrCtrl & ~wdata[`WRITE_COLLISION_FLAG_BIT]));
      mode_fault_flag_reg <= modeFault | (mode_fault_flag_reg & ~(wrCtrl & ~wdata[`MODE_FAULT_FLAG_BIT]));
      ovr_reg  <= (slaveDone & ~rxEmpty_reg)
                | (ovr_reg & ~(wrCtrl & ~wdata[`OVR_BIT]));
    end
  end

  // Transmit buffer; a full buffer refuses the write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txBuf_reg  <= 8'h00;
      txFull_reg <= 1'b0;
    end else begin
      if (masterStart | slaveLoad) begin
        txFull_reg <= 1'b0;
      end else if (wrData & ~txFull_reg) begin
        txBuf_reg  <= wdata;
        txFull_reg <= 1'b1;
      end
    end
  end

  // Bit counter; disabling the port is the only reset in 3-wire slave mode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bitCnt_reg <= 3'h0;
    end else if (!enable_reg) begin
      bitCnt_reg <= 3'h0;
    end else if (!master_reg && mode_reg == `SEL_MULTI && selFall) begin
      bitCnt_reg <= 3'h0;
    end else if (masterStart) begin
      bitCnt_reg <= 3'h0;
    end else if (mState_reg == M_HIGH && halfEnd) begin
      bitCnt_reg <= bitCnt_reg + 3'h1;
    end else if (slaveOn && sckRise) begin
      bitCnt_reg <= bitCnt_reg + 3'h1;
    end
  end

  // Master sequencer, one SCK cycle is two half periods
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mState_reg  <= M_IDLE;
      halfCnt_reg <= 8'h00;
      sck_reg     <= 1'b0;
      sample_reg  <= 1'b0;
    end else if (!masterOn || modeFault) begin
      mState_reg  <= M_IDLE;
      halfCnt_reg <= 8'h00;
      sck_reg     <= 1'b0;
    end else begin
      halfCnt_reg <= halfEnd ? 8'h00 : halfCnt_reg + 8'h01;
      case (mState_reg)
        M_IDLE: begin
          halfCnt_reg <= 8'h00;
          if (masterStart) begin
            mState_reg <= M_LOW;
          end
        end
        M_LOW: begin
          if (halfEnd) begin
            mState_reg <= M_HIGH;
            sck_reg    <= 1'b1;
            sample_reg <= misoS_reg[1];
          end
        end
        M_HIGH: begin
          if (halfEnd) begin
            sck_reg    <= 1'b0;
            mState_reg <= (bitCnt_reg == `LAST_BIT) ? M_LAST : M_LOW;
          end
        end
        M_LAST: begin
          mState_reg <= M_IDLE;
        end
        default: begin
          mState_reg <= M_IDLE;
        end
      endcase
    end
  end

  // Shift register, MSB first in both roles
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg   <= 8'h00;
      shEmpty_reg <= 1'b1;
    end else if (masterStart || slaveLoad) begin
      shift_reg   <= txBuf_reg;
      shEmpty_reg <= 1'b0;
    end else if (mState_reg == M_HIGH && halfEnd) begin
      shift_reg   <= {shift_reg[6:0], sample_reg};
    end else if (masterDone) begin
      shEmpty_reg <= 1'b1;
    end else if (slaveOn && sckRise) begin
      shift_reg   <= {shift_reg[6:0], mosiS_reg[1]};
      shEmpty_reg <= slaveDone;
    end
  end

  // Receive buffer; a slave overrun drops the new byte
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxBuf_reg   <= 8'h00;
      rxEmpty_reg <= 1'b1;
    end else if (masterDone) begin
      rxBuf_reg   <= shift_reg;
      rxEmpty_reg <= 1'b0;
    end else if (slaveDone && rxEmpty_reg) begin
      rxBuf_reg   <= {shift_reg[6:0], mosiS_reg[1]};
      rxEmpty_reg <= 1'b0;
    end else if (rdData) begin
      rxEmpty_reg <= 1'b1;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (!rd) begin
      rdata_reg <= 8'h00;
    end else begin
      case (addr)
        `CTRL_ADDR: rdata_reg <= {done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovr_reg,
                                  mode_reg, ~txFull_reg, enable_reg};
        `CFG_ADDR:  rdata_reg <= {(mState_reg != M_IDLE) | (bitCnt_reg != 3'h0),
                                  master_reg, 2'b00, selLow, selS_reg[1],
                                  master_reg | shEmpty_reg,
                                  master_reg | rxEmpty_reg};
        `DATA_ADDR: rdata_reg <= rxBuf_reg;
        default:    rdata_reg <= 8'h00;
      endcase
    end
  end

  // Pin enables registered so every output comes from a flop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sckOe_reg  <= 1'b0;
      misoOe_reg <= 1'b0;
      selNOe_reg <= 1'b0;
      routed_reg <= 1'b0;
    end else begin
      sckOe_reg  <= masterOn;
      misoOe_reg <= slaveOn;
      selNOe_reg <= mode_reg[1];
      routed_reg <= (mode_reg != `SEL_3WIRE);
    end
  end

  assign rdata     = rdata_reg;
  assign sckOut    = sck_reg;
  assign sckOe     = sckOe_reg;
  assign mosiOut   = shift_reg[7];
  assign mosiOe    = sckOe_reg;
  assign misoOut   = shift_reg[7];
  assign misoOe    = misoOe_reg;
  assign selNOut   = mode_reg[0];
  assign selNOe    = selNOe_reg;
  assign selRouted = routed_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence masterKick;
    masterStart ##1 (mState_reg == M_LOW);
  endsequence

  chk_fault_disables: assert property (modeFault |=>
      !enable_reg && !master_reg && mode_fault_flag_reg)
    else $error("mode fault left port enabled");
  chk_master_load: assert property (masterStart |-> ##1
      (shift_reg == $past(txBuf_reg)) && !txFull_reg)
    else $error("master start did not load shifter");
  chk_master_done: assert property (masterKick |-> ##[60:70] masterDone)
    else $error("master byte did not finish in time");
  chk_rx_capture: assert property (masterDone |=>
      done_reg && !rxEmpty_reg && rxBuf_reg == $past(shift_reg))
    else $error("master byte not captured");
  chk_write_collision_flag_discard: assert property (wcolEv && !masterStart && !slaveLoad |=>
      write_collision_flag_reg && txBuf_reg == $past(txBuf_reg))
    else $error("colliding write not dropped");
  chk_overrun_keep: assert property (slaveDone && !rxEmpty_reg && !rdData |=>
      ovr_reg && rxBuf_reg == $past(rxBuf_reg))
    else $error("overrun replaced buffer");
  chk_slave_count: assert property (slaveDone |=> done_reg && bitCnt_reg == 3'h0)
    else $error("slave byte end wrong");
  chk_sel_fall_cnt: assert property (enable_reg && !master_reg && selFall &&
      mode_reg == `SEL_MULTI |=> bitCnt_reg == 3'h0)
    else $error("select fall kept count");
  chk_slave_no_sck: assert property (!masterOn |=> !sckOe)
    else $error("slave drove SCK");
  chk_miso_float: assert property (!enable_reg ||
      (mode_reg == `SEL_MULTI && !selLow) |=> !misoOe)
    else $error("MISO driven while unselected");

endmodule
`default_nettype wire

// ---- tb/spi_far_side.sv ----
`default_nettype none
module spi_far_side (
  input  wire logic sckW,
  input  wire logic mosiW,
  input  wire logic misoW,
  output logic      pSck,
  output logic      pMosi,
  output logic      pMiso,
  output logic      pSel
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       drv = 1'b0;
  logic [2:0] sCnt = 3'h0;
  logic [7:0] sTx = 8'h00;
  logic [7:0] sRx = 8'h00;
  logic [7:0] mRx = 8'h00;
  logic [7:0] sGot[$];
  initial begin
    pSck = 1'b0;
    pMosi = 1'b0;
    pSel = 1'b1;
  end
  assign pMiso = sTx[7];
  // Lone slave: no select of its own, counts every rising edge it does not drive itself
  always @(posedge sckW) if (!drv) begin
    sRx = {sRx[6:0], mosiW};
    sCnt = sCnt + 3'h1;
    if (sCnt == 3'h0) sGot.push_back(sRx);
  end
  // Rotation hands the same byte out again next time
  always @(negedge sckW) if (!drv) sTx <= {sTx[6:0], sTx[7]};
  task automatic load(input logic [7:0] b);
    sTx = b;
  endtask
  // Clock stands low outside frames
  task automatic frame(input logic [7:0] b, input int n, input logic sel);
    drv = 1'b1;
    pSel = ~sel;
    #40;
    for (int i = 0; i < n; i++) begin
      pMosi = b[7 - i];
      #32 pSck = 1'b1;
      mRx = {mRx[6:0], misoW};
      #32 pSck = 1'b0;
    end
    #40 pSel = 1'b1;
    pMosi = ~pMosi;
    #40 drv = 1'b0;
  endtask
  task automatic pull_sel(input int t);
    pSel = 1'b0;
    #(t);
    pSel = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- tb/spi_master_slave_select_modes_tb.sv ----
`include "serial_port_map.svh"
`default_nettype none
module spi_master_slave_select_modes_tb;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
  typedef struct {logic [7:0] val; logic [7:0] mask;} note_t;
  logic        core_clk, nrst, wr, rd;
  logic        rdSeen = 1'b0;
  logic [1:0]  addr;
  logic [7:0]  wdata, rdata, d1, d2, d3, s, m, g;
  logic        sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, selNOut, selNOe, selRouted;
  logic        pSck, pMosi, pMiso, pSel, sckW, mosiW, misoW, selW;
  logic [31:0] seed = 32'd26;
  int          n_fail = 0;
  int          check_count = 0;
  note_t       cur;
  note_t       expQ[$];
  assign sckW = sckOe ? sckOut : pSck;
  assign mosiW = mosiOe ? mosiOut : pMosi;
  assign misoW = misoOe ? misoOut : pMiso;
  assign selW = selNOe ? selNOut : pSel;
  serial_port uut (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sckIn(sckW), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiW),
    .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe),
    .selNIn(selW), .selNOut(selNOut), .selNOe(selNOe), .selRouted(selRouted));
  spi_far_side p (.sckW(sckW), .mosiW(mosiW), .misoW(misoW), .pSck(pSck), .pMosi(pMosi),
    .pMiso(pMiso), .pSel(pSel));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_exp(input logic [1:0] a, input logic [7:0] v, input logic [7:0] k);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    expQ.push_back('{v, k});
    @(posedge core_clk);
    rd <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Polls are noted with an empty mask so the queue stays in step
  task automatic wait_done();
    for (int i = 0; i < 300; i++) begin
      rd_exp(`CTRL_ADDR, 8'h00, 8'h00);
      #1;
      if (rdata[`DONE_BIT] === 1'b1) return;
    end
    n_fail++;
    $display("[ERR] %0t no completion", $time);
  endtask
  always @(posedge core_clk) begin
    if (rdSeen) begin
      cur = expQ.pop_front();
      `CHK(rdata & cur.mask, cur.val)
    end
    rdSeen <= rd;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rd_exp(`CTRL_ADDR, 8'h06, 8'hff);
    rd_exp(`CFG_ADDR, 8'h07, 8'hff);
    rd_exp(2'h3, 8'h00, 8'hff);
    $display("reset values done");
    wr_reg(`CFG_ADDR, 8'h40);
    wr_reg(`CTRL_ADDR, 8'h01);
    s = rnd();
    d1 = rnd();
    d2 = rnd();
    d3 = rnd();
    p.load(s);
    settle(2);
    `CHK(selRouted, 1'b0)
    `CHK(sckOe, 1'b1)
    wr_reg(`DATA_ADDR, d1);
    repeat (3) @(posedge core_clk);
    wr_reg(`DATA_ADDR, d2);
    wr_reg(`DATA_ADDR, d3);
    rd_exp(`CTRL_ADDR, 8'h40, 8'h42);
    wait_done();
    g = p.sGot.pop_front();
    `CHK(g, d1)
    rd_exp(`DATA_ADDR, s, 8'hff);
    wr_reg(`CTRL_ADDR, 8'h01);
    wait_done();
    g = p.sGot.pop_front();
    `CHK(g, d2)
    rd_exp(`DATA_ADDR, s, 8'hff);
    $display("master transfer done");
    wr_reg(`CTRL_ADDR, 8'h0d);
    settle(2);
    `CHK({selNOe, selNOut, selRouted}, 3'b111)
    wr_reg(`CTRL_ADDR, 8'h09);
    settle(2);
    `CHK({selNOe, selNOut}, 2'b10)
    wr_reg(`CTRL_ADDR, 8'h05);
    settle(6);
    p.pull_sel(200);
    rd_exp(`CTRL_ADDR, 8'h20, 8'h21);
    rd_exp(`CFG_ADDR, 8'h00, 8'h40);
    #1;
    `CHK(sckOe, 1'b0)
    $display("select modes and fault done");
    wr_reg(`CTRL_ADDR, 8'h05);
    settle(2);
    `CHK(misoOe, 1'b0)
    m = rnd();
    p.frame(m, 8, 1'b0);
    rd_exp(`CTRL_ADDR, 8'h00, 8'h80);
    s = rnd();
    wr_reg(`DATA_ADDR, s);
    settle(2);
    `CHK({sckOe, mosiOe}, 2'b00)
    p.frame(m, 8, 1'b1);
    settle(8);
    `CHK(p.mRx, s)
    rd_exp(`CTRL_ADDR, 8'h80, 8'h80);
    rd_exp(`DATA_ADDR, m, 8'hff);
    wr_reg(`CTRL_ADDR, 8'h05);
    p.frame(rnd(), 3, 1'b1);
    m = rnd();
    p.frame(m, 8, 1'b1);
    settle(8);
    rd_exp(`DATA_ADDR, m, 8'hff);
    d1 = rnd();
    p.frame(d1, 8, 1'b1);
    p.frame(rnd(), 8, 1'b1);
    settle(8);
    rd_exp(`CTRL_ADDR, 8'h10, 8'h10);
    rd_exp(`DATA_ADDR, d1, 8'hff);
    $display("four wire slave done");
    wr_reg(`CTRL_ADDR, 8'h01);
    settle(2);
    `CHK(misoOe, 1'b1)
    p.frame(rnd(), 3, 1'b0);
    wr_reg(`CTRL_ADDR, 8'h00);
    wr_reg(`CTRL_ADDR, 8'h01);
    m = rnd();
    p.frame(m, 8, 1'b0);
    settle(8);
    rd_exp(`DATA_ADDR, m, 8'hff);
    settle(2);
    $display("three wire slave done");
    final_report();
  end
endmodule
`default_nettype wire
